//--- bkc_top.sv
// Purpose: hardware breakpoint comparator watching the core bus
// Assumes: core bus, debug flags and register port all on mclk
// Notes:   program breakpoints go out as a tag and break when the core
//          reports the tagged opcode at the queue head
`timescale 1ns/1ns
module bkc_top
   import bkc_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // core bus and queue
   input  wire bkc_bus_s   cpu_bus,
   input  wire logic       instr_boundary,
   input  wire logic       tag_at_head,
   // debug unit
   input  wire logic       dbg_active,
   input  wire logic       dbg_enable,
   // requests
   output logic            tag_req,
   output logic            swi_req,
   output logic            dbg_req
);
   // =====================================================================
   // state
   bkc_state_s st_ff;
   bkc_state_s nxt_st;

   bkc_mode_e  mode;
   logic       dual;
   logic       prog;
   logic       dbe;
   logic       qual;
   logic [1:0] cmp_match;
   logic [7:0] c_hi [2];
   logic [7:0] c_lo [2];
   logic [1:0] c_hien;
   logic [1:0] c_loen;
   logic [1:0] c_rwen;
   logic [1:0] c_rwv;
   logic [15:0] c_val [2];
   logic       hit0;
   logic       hit1;
   logic       hit;

   assign mode = bkc_mode_e'(st_ff.ctl0[C0_MODE_HI:C0_MODE_LO]);
   assign dual = (mode == BKC_SWI_DUAL) || (mode == BKC_DBG_DUAL);
   // swi dual always behaves as program-only whatever the bit says
   assign prog = st_ff.ctl0[C0_PM] || (mode == BKC_SWI_DUAL);
   assign dbe  = st_ff.ctl1[C1_DBE];
   // nothing counts during firmware execution or outside bus cycles
   assign qual = cpu_bus.valid && !dbg_active && (mode != BKC_OFF)
               && (!prog || cpu_bus.fetch);

   // =====================================================================
   // compare setup per breakpoint
   always_comb begin
      c_hi[0]   = st_ff.ahi;
      c_lo[0]   = st_ff.alo;
      c_val[0]  = cpu_bus.addr;
      c_hien[0] = 1'b1;
      c_loen[0] = st_ff.ctl0[C0_RANGE0];
      // direction ignored in swi dual and for program breaks
      c_rwen[0] = st_ff.ctl1[C1_RWE0] && !prog;
      c_rwv[0]  = st_ff.ctl1[C1_RW0];
      c_hi[1]   = st_ff.dhi;
      c_lo[1]   = st_ff.dlo;
      c_rwv[1]  = st_ff.ctl1[C1_RW1];
      if (mode == BKC_DBG_FULL) begin
         c_val[1]  = cpu_bus.data;
         c_hien[1] = !st_ff.ctl1[C1_MBH];
         c_loen[1] = !st_ff.ctl1[C1_MBL];
         c_rwen[1] = 1'b0;
      end else begin
         c_val[1]  = cpu_bus.addr;
         c_hien[1] = 1'b1;
         c_loen[1] = st_ff.ctl0[C0_RANGE1];
         c_rwen[1] = st_ff.ctl1[C1_RWE1] && !prog;
      end
   end

   generate
      for (genvar g = 0; g < 2; g++) begin : g_cmp
         bkc_cmp u_cmp (
            .ref_hi (c_hi[g]),
            .ref_lo (c_lo[g]),
            .hi_en  (c_hien[g]),
            .lo_en  (c_loen[g]),
            .rw_en  (c_rwen[g]),
            .rw_val (c_rwv[g]),
            .value  (c_val[g]),
            .bus_rd (cpu_bus.rd),
            .match  (cmp_match[g])
         );
      end
   endgenerate

   // =====================================================================
   // match decision; no access size bit exists, so size never qualifies
   always_comb begin
      // full mode with DBE set: the data compare must agree in the same cycle
      hit0 = qual && cmp_match[0]
           && (dual || !dbe || cmp_match[1]);
      hit1 = qual && dual && dbe && cmp_match[1];
      hit  = hit0 || hit1;
   end

   // =====================================================================
   // next state
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.tag_req = 1'b0;
      nxt_st.swi_req = 1'b0;
      nxt_st.dbg_req = 1'b0;
      nxt_st.rdata   = BKC_RST_VAL;

      // program breaks tag the fetch; the kind rides with the tag
      if (hit && prog) begin
         nxt_st.tag_req = 1'b1;
         nxt_st.tag_swi = (mode == BKC_SWI_DUAL);
      end

      if (tag_at_head) begin
         if (st_ff.tag_swi) begin
            nxt_st.swi_req = 1'b1;
         end else if (dbg_enable && !dbg_active) begin
            nxt_st.dbg_req = 1'b1;
         end
      end

      // data breaks wait for the instruction boundary; no lockout after
      // one, so a recurring match breaks again
      if (instr_boundary && st_ff.stat[ST_PEND]) begin
         nxt_st.stat[ST_PEND] = 1'b0;
         if (dbg_enable && !dbg_active) begin
            nxt_st.dbg_req = 1'b1;
         end
      end
      if (hit && !prog) begin
         nxt_st.stat[ST_PEND] = 1'b1;
      end

      // register writes
      if (reg_wr) begin
         case (reg_addr)
            BKC_CTL0_OFS: nxt_st.ctl0 = reg_wdata & BKC_CTL0_MASK;
            BKC_CTL1_OFS: nxt_st.ctl1 = reg_wdata & BKC_CTL1_MASK;
            BKC_AHI_OFS:  nxt_st.ahi  = reg_wdata;
            BKC_ALO_OFS:  nxt_st.alo  = reg_wdata;
            BKC_DHI_OFS:  nxt_st.dhi  = reg_wdata;
            BKC_DLO_OFS:  nxt_st.dlo  = reg_wdata;
            BKC_STAT_OFS: begin
               // write one clears a hit flag
               if (reg_wdata[ST_HIT0]) nxt_st.stat[ST_HIT0] = 1'b0;
               if (reg_wdata[ST_HIT1]) nxt_st.stat[ST_HIT1] = 1'b0;
            end
            default: ;
         endcase
      end
      // a hit in the clearing cycle wins
      if (hit0) nxt_st.stat[ST_HIT0] = 1'b1;
      if (hit1) nxt_st.stat[ST_HIT1] = 1'b1;

      // register reads, data stand the following cycle
      if (reg_rd) begin
         case (reg_addr)
            BKC_CTL0_OFS: nxt_st.rdata = st_ff.ctl0;
            BKC_CTL1_OFS: nxt_st.rdata = st_ff.ctl1;
            BKC_AHI_OFS:  nxt_st.rdata = st_ff.ahi;
            BKC_ALO_OFS:  nxt_st.rdata = st_ff.alo;
            BKC_DHI_OFS:  nxt_st.rdata = st_ff.dhi;
            BKC_DLO_OFS:  nxt_st.rdata = st_ff.dlo;
            BKC_STAT_OFS: nxt_st.rdata = {5'h00, st_ff.stat};
            default:      nxt_st.rdata = BKC_RST_VAL;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign tag_req   = st_ff.tag_req;
   assign swi_req   = st_ff.swi_req;
   assign dbg_req   = st_ff.dbg_req;

   // =====================================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_prog_hit;
      hit && prog;
   endsequence
   sequence s_boundary_take;
      instr_boundary && st_ff.stat[ST_PEND] && dbg_enable && !dbg_active;
   endsequence
   sequence s_ctl0_wr_rd;
      (reg_wr && reg_addr == BKC_CTL0_OFS) ##1 (reg_rd && !reg_wr && reg_addr == BKC_CTL0_OFS);
   endsequence
   sequence s_ctl1_wr_rd;
      (reg_wr && reg_addr == BKC_CTL1_OFS) ##1 (reg_rd && !reg_wr && reg_addr == BKC_CTL1_OFS);
   endsequence

   off_mode_quiet_a: assert property (
      (mode == BKC_OFF) |-> !hit)
      else $error("match while breakpoints off");
   active_no_hit_a: assert property (
      dbg_active |-> !hit)
      else $error("match during debug firmware");
   swi_source_a: assert property (
      swi_req |-> $past(tag_at_head) && $past(st_ff.tag_swi))
      else $error("swi without swi tag at head");
   swi_fetch_only_a: assert property (
      (mode == BKC_SWI_DUAL && hit) |-> cpu_bus.fetch)
      else $error("swi dual mode hit on data access");
   second_off_a: assert property (
      (dual && !dbe) |-> !hit1)
      else $error("second breakpoint hit while disabled");
   dbg_gate_a: assert property (
      $rose(dbg_req) |-> $past(dbg_enable))
      else $error("debug entry without debug enable");
   prog_tag_a: assert property (
      s_prog_hit |=> tag_req && !st_ff.stat[ST_PEND])
      else $error("program hit did not tag");
   boundary_break_a: assert property (
      s_boundary_take |=> dbg_req)
      else $error("pending break not taken at boundary");
   ctl0_readback_a: assert property (
      s_ctl0_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & BKC_CTL0_MASK))
      else $error("control 0 readback wrong");
   ctl1_readback_a: assert property (
      s_ctl1_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & BKC_CTL1_MASK))
      else $error("control 1 readback wrong");
   rdata_idle_a: assert property (
      !reg_rd |=> reg_rdata == BKC_RST_VAL)
      else $error("read data not idle");
   reset_zero_a: assert property (
      $fell(sys_rst) |-> st_ff.ctl0 == BKC_RST_VAL && st_ff.ctl1 == BKC_RST_VAL)
      else $error("control not zero after reset");

   // =====================================================================
   // qualifiers, stated from the register bits rather than the compare setup
   first_hi_a: assert property (
      (qual && cpu_bus.addr[15:8] != st_ff.ahi) |-> !hit0)
      else $error("first break hit on wrong high address");
   first_lo_a: assert property (
      (qual && st_ff.ctl0[C0_RANGE0] && cpu_bus.addr[7:0] != st_ff.alo) |-> !hit0)
      else $error("first break hit on wrong low address");
   first_range_a: assert property (
      (qual && !st_ff.ctl0[C0_RANGE0] && cpu_bus.addr[15:8] == st_ff.ahi
         && (!st_ff.ctl1[C1_RWE0] || prog)
         && (dual || !dbe || cpu_bus.data == {st_ff.dhi, st_ff.dlo})) |-> hit0)
      else $error("first break missed on high address");
   second_lo_a: assert property (
      (dual && st_ff.ctl0[C0_RANGE1] && cpu_bus.addr[7:0] != st_ff.dlo) |-> !hit1)
      else $error("second break hit on wrong low address");
   second_range_a: assert property (
      (dual && qual && dbe && !st_ff.ctl0[C0_RANGE1] && cpu_bus.addr[15:8] == st_ff.dhi
         && (!st_ff.ctl1[C1_RWE1] || prog)) |-> hit1)
      else $error("second break missed on high address");
   second_gate_a: assert property (
      (dual && qual && dbe && cpu_bus.addr == {st_ff.dhi, st_ff.dlo}
         && (!st_ff.ctl1[C1_RWE1] || prog)) |-> hit1)
      else $error("enabled second break missed");
   second_dir_a: assert property (
      (dual && !prog && st_ff.ctl1[C1_RWE1] && cpu_bus.rd != st_ff.ctl1[C1_RW1]) |-> !hit1)
      else $error("second break hit on wrong direction");
   first_dir_a: assert property (
      (!prog && st_ff.ctl1[C1_RWE0] && cpu_bus.rd != st_ff.ctl1[C1_RW0]) |-> !hit0)
      else $error("first break hit on wrong direction");
   swi_dir_free_a: assert property (
      (mode == BKC_SWI_DUAL && qual && cpu_bus.addr[15:8] == st_ff.ahi
         && (!st_ff.ctl0[C0_RANGE0] || cpu_bus.addr[7:0] == st_ff.alo)) |-> hit0)
      else $error("swi dual break blocked by direction");
   prog_dir_free_a: assert property (
      (mode == BKC_DBG_DUAL && st_ff.ctl0[C0_PM] && qual && cpu_bus.addr[15:8] == st_ff.ahi
         && (!st_ff.ctl0[C0_RANGE0] || cpu_bus.addr[7:0] == st_ff.alo)) |-> hit0)
      else $error("program break blocked by direction");
   full_single_a: assert property (
      (mode == BKC_DBG_FULL) |-> !hit1)
      else $error("second break hit in full mode");
   high_mask_a: assert property (
      (mode == BKC_DBG_FULL && dbe && !st_ff.ctl1[C1_MBH] && cpu_bus.data[15:8] != st_ff.dhi) |-> !hit)
      else $error("full break ignored high data byte");
   low_mask_a: assert property (
      (mode == BKC_DBG_FULL && dbe && !st_ff.ctl1[C1_MBL] && cpu_bus.data[7:0] != st_ff.dlo) |-> !hit)
      else $error("full break ignored low data byte");
   masks_free_a: assert property (
      (mode == BKC_DBG_FULL && st_ff.ctl1[C1_MBH] && st_ff.ctl1[C1_MBL] && qual
         && cpu_bus.addr[15:8] == st_ff.ahi && (!st_ff.ctl0[C0_RANGE0] || cpu_bus.addr[7:0] == st_ff.alo)
         && (!st_ff.ctl1[C1_RWE0] || prog || cpu_bus.rd == st_ff.ctl1[C1_RW0])) |-> hit0)
      else $error("masked data still blocked full break");

   // =====================================================================
   // tag kind and queue head
   swi_tag_kind_a: assert property (
      (hit && mode == BKC_SWI_DUAL) |=> tag_req && st_ff.tag_swi)
      else $error("swi dual hit not tagged as swi");
   dbg_tag_kind_a: assert property (
      (hit && prog && mode != BKC_SWI_DUAL) |=> !st_ff.tag_swi)
      else $error("debug program break tagged as swi");
   head_no_swi_a: assert property (
      (tag_at_head && !st_ff.tag_swi) |=> !swi_req)
      else $error("swi from a debug tag");
   head_debug_a: assert property (
      (tag_at_head && !st_ff.tag_swi && dbg_enable && !dbg_active) |=> dbg_req)
      else $error("debug tag at head did not break");
   data_pend_a: assert property (
      (hit && !prog) |=> st_ff.stat[ST_PEND])
      else $error("data break not held for the boundary");
endmodule : bkc_top

//--- bkc_pkg.sv
// Purpose: shared constants and types for the breakpoint comparator
// Assumes: 8-bit register port, 16-bit core address and data buses
// Notes:   byte offsets are the register addresses seen by software
package bkc_pkg;
   // =====================================================================
   // register map
   localparam logic [7:0] BKC_CTL0_OFS = 8'h20;
   localparam logic [7:0] BKC_CTL1_OFS = 8'h21;
   localparam logic [7:0] BKC_AHI_OFS  = 8'h22;
   localparam logic [7:0] BKC_ALO_OFS  = 8'h23;
   localparam logic [7:0] BKC_DHI_OFS  = 8'h24;
   localparam logic [7:0] BKC_DLO_OFS  = 8'h25;
   localparam logic [7:0] BKC_STAT_OFS = 8'h26;
   localparam logic [7:0] BKC_RST_VAL  = 8'h00;
   // writable bits; the rest are fixed zero
   localparam logic [7:0] BKC_CTL0_MASK = 8'hEC;
   localparam logic [7:0] BKC_CTL1_MASK = 8'h7F;
   // =====================================================================
   // field positions
   localparam int C0_MODE_HI = 7;
   localparam int C0_MODE_LO = 6;
   localparam int C0_PM      = 5;
   localparam int C0_RANGE1  = 3;
   localparam int C0_RANGE0  = 2;
   localparam int C1_DBE     = 6;
   localparam int C1_MBH     = 5;
   localparam int C1_MBL     = 4;
   localparam int C1_RWE1    = 3;
   localparam int C1_RW1     = 2;
   localparam int C1_RWE0    = 1;
   localparam int C1_RW0     = 0;
   localparam int ST_HIT0    = 0;
   localparam int ST_HIT1    = 1;
   localparam int ST_PEND    = 2;
   localparam int ST_W       = 3;
   // =====================================================================
   // types
   typedef enum logic [1:0] {
      BKC_OFF      = 2'h0,
      BKC_SWI_DUAL = 2'h1,
      BKC_DBG_FULL = 2'h2,
      BKC_DBG_DUAL = 2'h3
   } bkc_mode_e;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
      logic        rd;
      logic        valid;
      logic        fetch;
   } bkc_bus_s;

   typedef struct packed {
      logic [7:0]      ctl0;
      logic [7:0]      ctl1;
      logic [7:0]      ahi;
      logic [7:0]      alo;
      logic [7:0]      dhi;
      logic [7:0]      dlo;
      logic [ST_W-1:0] stat;
      logic            tag_swi;
      logic            tag_req;
      logic            swi_req;
      logic            dbg_req;
      logic [7:0]      rdata;
   } bkc_state_s;
endpackage : bkc_pkg

//--- bkc_cmp.sv
// Purpose: one 16-bit byte-qualified compare with optional direction check
// Assumes: all inputs from the same clock domain, purely combinational
// Notes:   a disabled byte or direction check counts as matching
`timescale 1ns/1ns
module bkc_cmp
   import bkc_pkg::*;
(
   // reference
   input  wire logic [7:0]  ref_hi,
   input  wire logic [7:0]  ref_lo,
   input  wire logic        hi_en,
   input  wire logic        lo_en,
   input  wire logic        rw_en,
   input  wire logic        rw_val,
   // observed bus
   input  wire logic [15:0] value,
   input  wire logic        bus_rd,
   // result
   output logic             match
);
   always_comb begin
      match = (!hi_en || value[15:8] == ref_hi)
            && (!lo_en || value[7:0] == ref_lo)
            && (!rw_en || bus_rd == rw_val);
   end
endmodule : bkc_cmp

//--- bkc_core_mdl.sv
// Purpose: core queue and debug unit stand-in for the comparator
// Assumes: tag and debug requests arrive as one-cycle pulses
// Notes:   queue latency alternates short and long to stress both paths
`timescale 1ns/1ns
module bkc_core_mdl
   import bkc_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // from comparator
   input  wire logic tag_req,
   input  wire logic dbg_req,
   // from bench
   input  wire logic fw_hold,
   // to comparator
   output logic      tag_at_head,
   output logic      dbg_active
);
   // =====================================================================
   // queue head and firmware run
   logic [2:0] head_ff;
   logic [2:0] fw_ff;
   logic       slow_ff;

   always_ff @(posedge mclk) begin
      tag_at_head <= 1'b0;
      if (sys_rst) begin
         head_ff <= 3'h0;
         fw_ff   <= 3'h0;
         slow_ff <= 1'b0;
      end else begin
         if (tag_req) begin
            head_ff <= slow_ff ? 3'h5 : 3'h1;
            slow_ff <= ~slow_ff;
         end else if (head_ff != 3'h0) begin
            head_ff     <= head_ff - 3'h1;
            tag_at_head <= (head_ff == 3'h1);
         end
         // firmware runs six cycles after a debug request, then returns to normal flow
         if (dbg_req) fw_ff <= 3'h6;
         else if (fw_ff != 3'h0) fw_ff <= fw_ff - 3'h1;
      end
   end

   assign dbg_active = fw_hold || (fw_ff != 3'h0);
endmodule : bkc_core_mdl

//--- tb_bkc_top.sv
// Purpose: self-checking bench for the breakpoint comparator
// Assumes: compare registers at their package offsets
// Notes:   each hit watches a fixed window long enough for slow tags
`timescale 1ns/1ns
module tb_bkc_top;
   import bkc_pkg::*;
   // =====================================================================
   // signals
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       mclk, sys_rst, reg_wr, reg_rd, instr_boundary, dbg_enable, fw_hold;
   logic       tag_at_head, dbg_active, tag_req, swi_req, dbg_req;
   bkc_bus_s   cpu_bus;
   int         err_count, compares;

   bkc_top bkc_top_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_bus(cpu_bus),
      .instr_boundary(instr_boundary), .tag_at_head(tag_at_head), .dbg_active(dbg_active),
      .dbg_enable(dbg_enable), .tag_req(tag_req), .swi_req(swi_req), .dbg_req(dbg_req));
   bkc_core_mdl bkc_core_mdl_i (.mclk(mclk), .sys_rst(sys_rst), .tag_req(tag_req), .dbg_req(dbg_req),
      .fw_hold(fw_hold), .tag_at_head(tag_at_head), .dbg_active(dbg_active));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // =====================================================================
   // shared tasks
   task automatic test_done();
      if (err_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask : rd

   // write then read back with no gap between the strobes, then idle data
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
      @(posedge mclk);
      #1;
      chk(reg_rdata, BKC_RST_VAL);
   endtask : wr_rd

   // one bus cycle, a boundary, then the seen pulses {tag, swi, dbg}
   task automatic hit(input logic [15:0] a, input logic [15:0] d, input logic r, input logic f,
                      input logic [7:0] e);
      logic [7:0] seen;
      seen = 8'h00;
      @(posedge mclk);
      cpu_bus <= '{addr: a, data: d, rd: r, valid: 1'b1, fetch: f};
      for (int i = 0; i < 18; i++) begin
         @(posedge mclk);
         cpu_bus.valid  <= 1'b0;
         instr_boundary <= (i == 0);
         #1;
         seen = seen | {5'h00, tag_req, swi_req, dbg_req};
      end
      chk(seen, e);
   endtask : hit
   // =====================================================================
   // scenarios
   task automatic t_regs();
      rd(BKC_CTL0_OFS, 8'h00);
      rd(BKC_CTL1_OFS, 8'h00);
      wr(BKC_CTL0_OFS, 8'hFF);
      wr(BKC_CTL1_OFS, 8'hFF);
      rd(BKC_CTL0_OFS, 8'hEC);
      rd(BKC_CTL1_OFS, 8'h7F);
      wr(8'h30, 8'h5A);
      rd(8'h30, 8'h00);
      wr_rd(BKC_CTL0_OFS, 8'hA7, 8'hA4);
      wr_rd(BKC_CTL1_OFS, 8'hB5, 8'h35);
      wr(BKC_AHI_OFS, 8'h12);
      wr(BKC_ALO_OFS, 8'h34);
      wr(BKC_DHI_OFS, 8'hAB);
      wr(BKC_DLO_OFS, 8'hCD);
      rd(BKC_DLO_OFS, 8'hCD);
   endtask : t_regs

   task automatic t_full();
      wr(BKC_CTL0_OFS, 8'h84);
      wr(BKC_CTL1_OFS, 8'h40);
      hit(16'h1234, 16'hABCD, 1'b0, 1'b0, 8'h01);
      rd(BKC_STAT_OFS, 8'h01);
      wr(BKC_STAT_OFS, 8'h01);
      rd(BKC_STAT_OFS, 8'h00);
      hit(16'h1234, 16'hABCE, 1'b0, 1'b0, 8'h00);
      hit(16'h1234, 16'h12CD, 1'b0, 1'b0, 8'h00);
      hit(16'h1234, 16'hABCD, 1'b0, 1'b0, 8'h01);
      hit(16'h1299, 16'hABCD, 1'b0, 1'b0, 8'h00);
      wr(BKC_CTL0_OFS, 8'h80);
      hit(16'h1299, 16'hABCD, 1'b0, 1'b0, 8'h01);
      wr(BKC_CTL1_OFS, 8'h60);
      hit(16'h1299, 16'h00CD, 1'b1, 1'b0, 8'h01);
      hit(16'h1299, 16'h00CE, 1'b1, 1'b0, 8'h00);
      wr(BKC_CTL1_OFS, 8'h73);
      hit(16'h12EE, 16'h0000, 1'b0, 1'b0, 8'h00);
      hit(16'h12EE, 16'h0000, 1'b1, 1'b0, 8'h01);
      @(posedge mclk);
      dbg_enable <= 1'b0;
      hit(16'h12EE, 16'h0000, 1'b1, 1'b0, 8'h00);
      @(posedge mclk);
      dbg_enable <= 1'b1;
      fw_hold    <= 1'b1;
      hit(16'h12EE, 16'h0000, 1'b1, 1'b0, 8'h00);
      @(posedge mclk);
      fw_hold <= 1'b0;
   endtask : t_full

   task automatic t_swi();
      wr(BKC_CTL0_OFS, 8'h4C);
      wr(BKC_CTL1_OFS, 8'h0F);
      hit(16'h1234, 16'h0000, 1'b0, 1'b1, 8'h06);
      hit(16'h1234, 16'h0000, 1'b1, 1'b0, 8'h00);
      hit(16'hABCD, 16'h0000, 1'b1, 1'b1, 8'h00);
      wr(BKC_CTL1_OFS, 8'h4F);
      hit(16'hABCD, 16'h0000, 1'b0, 1'b1, 8'h06);
      wr(BKC_CTL0_OFS, 8'h64);
      hit(16'hABEE, 16'h0000, 1'b1, 1'b1, 8'h06);
   endtask : t_swi

   task automatic t_dual();
      wr(BKC_CTL0_OFS, 8'hCC);
      wr(BKC_CTL1_OFS, 8'h4C);
      hit(16'hABCD, 16'h0000, 1'b0, 1'b0, 8'h00);
      hit(16'hABCD, 16'h0000, 1'b1, 1'b0, 8'h01);
      wr(BKC_CTL0_OFS, 8'hEC);
      hit(16'hABCD, 16'h0000, 1'b1, 1'b0, 8'h00);
      hit(16'hABCD, 16'h0000, 1'b1, 1'b1, 8'h05);
      wr(BKC_CTL0_OFS, 8'h0C);
      hit(16'h1234, 16'hABCD, 1'b1, 1'b1, 8'h00);
   endtask : t_dual
   // =====================================================================
   // main sequence
   initial begin
      err_count      = 0;
      compares       = 0;
      sys_rst        = 1'b1;
      reg_addr       = 8'h00;
      reg_wdata      = 8'h00;
      reg_wr         = 1'b0;
      reg_rd         = 1'b0;
      cpu_bus        = '0;
      instr_boundary = 1'b0;
      dbg_enable     = 1'b0;
      fw_hold        = 1'b0;
      repeat (8) @(posedge mclk);
      sys_rst    <= 1'b0;
      dbg_enable <= 1'b1;
      t_regs();
      t_full();
      t_swi();
      t_dual();
      test_done();
   end
endmodule : tb_bkc_top
